/* File: hw/tci_params.svh */
/*
  Offsets, field positions, reset values and widths of the timer control block.
  Assumes it is included by bare name from every design file that needs it.
*/
`ifndef TCI_PARAMS_SVH
`define TCI_PARAMS_SVH

// ==========================================================
// Register byte offsets (one aligned 32-bit word each)
`define TCI_OFS_CTL 8'h00
`define TCI_OFS_COUNT 8'h04
`define TCI_OFS_PERIOD 8'h08
`define TCI_OFS_PRESCALE 8'h0C

// ==========================================================
// Control/status field positions
`define TCI_BIT_ZFLAG 15
`define TCI_BIT_ZIRQEN 14
`define TCI_BIT_FREE 11
`define TCI_BIT_SOFT 10

// ==========================================================
// Widths and reset values
`define TCI_ADDR_W 8
`define TCI_CNT_W 32
`define TCI_CTL_W 16
`define TCI_PERIOD_RST 32'hFFFFFFFF
`define TCI_PRESCALE_RST 32'h00000000
`define TCI_TRANS_NONSEQ 2'h2

`endif

/* File: hw/tci_pkg.sv */
/*
  Types shared by the timer control block.
  Assumes nothing of its surroundings.
*/
package tci_pkg;

  // ==========================================================
  // Types
  typedef logic [1:0] tci_trans_t;
  typedef logic [2:0] tci_size_t;

  // Emulation halt states, Gray along run, drain, stop
  typedef enum logic [1:0] {
    EMU_RUN = 2'h0,
    EMU_DRAIN = 2'h1,
    EMU_STOP = 2'h3
  } tci_emu_e;

endpackage

/* File: hw/tci_prescaler.sv */
/*
  Prescale divider: one tick every divisor plus one enabled clocks.
  Assumes divisor is static or changes between ticks harmlessly.
*/
`timescale 1ns/1ps
`include "tci_params.svh"

module tci_prescaler #(
  parameter int CntW = `TCI_CNT_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control
  input wire logic runEn,
  input wire logic [CntW-1:0] divisor,
  // Output
  output logic tick
);
  import tci_pkg::*;

  logic [CntW-1:0] psc_q;

  // Tick on the cycle the down-counter sits at zero
  assign tick = runEn && (psc_q == '0);

  // ==========================================================
  // Prescale counter
  // divide by divisor plus one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      psc_q <= '0;
    end else if (runEn) begin
      psc_q <= (psc_q == '0) ? divisor : psc_q - 1'b1;
    end
  end

  property p_psc_gap;
    @(posedge core_clk) disable iff (!rst_b)
      tick && (divisor != '0) |=> !tick;
  endproperty
  a_psc_gap: assert property (p_psc_gap) else $error("prescaler ticked twice in a row");

endmodule

/* File: hw/tci_emu_gate.sv */
/*
  Debug halt gate: decides whether the timer keeps counting during a halt.
  Assumes dbgHalt is synchronous to core_clk and held for the whole halt.
*/
`timescale 1ns/1ps
`include "tci_params.svh"

module tci_emu_gate (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Halt request and mode
  input wire logic dbgHalt,
  input wire logic freeRun,
  input wire logic softStop,
  // Counter events
  input wire logic decTick,
  input wire logic zeroEvt,
  // Output
  output logic runEn
);
  import tci_pkg::*;

  tci_emu_e emu_q;

  assign runEn = (emu_q != EMU_STOP);

  // ==========================================================
  // Halt state machine
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      emu_q <= EMU_RUN;
    end else begin
      case (emu_q)
        EMU_RUN: begin
          if (dbgHalt && !freeRun) begin
            emu_q <= EMU_DRAIN;
          end
        end
        EMU_DRAIN: begin
          if (!dbgHalt || freeRun) begin
            emu_q <= EMU_RUN;
          end else if (decTick && !softStop) begin
            emu_q <= EMU_STOP;
          end else if (decTick && zeroEvt) begin
            emu_q <= EMU_STOP;
          end
        end
        EMU_STOP: begin
          if (!dbgHalt || freeRun) begin
            emu_q <= EMU_RUN;
          end
        end
        default: begin
          emu_q <= EMU_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  property p_hard_stop;
    @(posedge core_clk) disable iff (!rst_b)
      (emu_q == EMU_DRAIN) && dbgHalt && !freeRun && !softStop && decTick |=> !runEn;
  endproperty
  a_hard_stop: assert property (p_hard_stop) else $error("hard stop missed");

  property p_soft_keep;
    @(posedge core_clk) disable iff (!rst_b)
      (emu_q == EMU_DRAIN) && softStop && decTick && !zeroEvt |=> runEn;
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft stop halted early");

  property p_soft_zero;
    @(posedge core_clk) disable iff (!rst_b)
      (emu_q == EMU_DRAIN) && dbgHalt && !freeRun && softStop && decTick && zeroEvt
      |=> !runEn;
  endproperty
  a_soft_zero: assert property (p_soft_zero) else $error("soft stop ran past zero");

  property p_resume;
    @(posedge core_clk) disable iff (!rst_b)
      !runEn && !dbgHalt |=> runEn;
  endproperty
  a_resume: assert property (p_resume) else $error("timer not resumed after halt");

  property p_stop_cause;
    @(posedge core_clk) disable iff (!rst_b)
      $fell(runEn) |-> $past(decTick);
  endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("halt without a decrement");

  c_hard: cover property (@(posedge core_clk) disable iff (!rst_b)
    $fell(runEn) && !softStop);
  c_soft: cover property (@(posedge core_clk) disable iff (!rst_b)
    $fell(runEn) && softStop);

endmodule

/* File: hw/tci_timer_ctl.sv */
/*
  Timer control and status block with down-counter, prescaler and debug halt,
  reached over AHB-Lite.
  Assumes a single AHB-Lite master, word transfers only, and inputs
  synchronous to core_clk.
*/
// Implementation choices: the placing of the registers and the AHB-Lite register port.
// Contract
// - The zero flag is set whenever the countdown value decrements to zero.
// - Writing one to the zero flag position clears the flag.
// - Writing zero to the zero flag position leaves the flag as it is.
// - The interrupt request is raised on zero only while the interrupt enable is one.
// - With free run set the timer keeps counting through a debug halt.
// - With free and soft clear the timer halts after the next decrement once halted.
// - With free clear and soft set the timer counts on to zero during a halt and stops.
// - In soft stop the zero interrupt is still produced before the timer stops.
// - The count drops once per divisor plus one clocks and reloads from the period at zero.
`timescale 1ns/1ps
`include "tci_params.svh"

module tci_timer_ctl #(
  parameter int CntW = `TCI_CNT_W,
  parameter int AddrW = `TCI_ADDR_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire tci_pkg::tci_trans_t htrans,
  input wire logic hwrite,
  input wire tci_pkg::tci_size_t hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Debug halt
  input wire logic dbgHalt,
  // Timer events and interrupt
  output logic zeroPulse,
  output logic irq
);
  import tci_pkg::*;

  // ==========================================================
  // Declarations
  logic wrPend_q;
  logic [AddrW-1:0] wrAddr_q;
  logic addrTaken;
  logic wrCtl;
  logic wrPeriod;
  logic wrPrescale;
  logic zero_flag_q;
  logic zero_irq_enable_q;
  logic free_q;
  logic soft_q;
  logic [CntW-1:0] countdown_value_q;
  logic [CntW-1:0] countdown_value_d;
  logic [CntW-1:0] reload_period_q;
  logic [CntW-1:0] prescale_divisor_q;
  logic [`TCI_CTL_W-1:0] ctlWord;
  logic runEn;
  logic decTick;
  logic zeroEvt;
  logic zeroClr;

  // ==========================================================
  // Bus answer: never stalls, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase accepted when selected, ready and NONSEQ
  assign addrTaken = hsel && hready && (htrans == `TCI_TRANS_NONSEQ);

  // Write data arrives one cycle after the address, so hold it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
    end else begin
      wrPend_q <= addrTaken && hwrite;
      if (addrTaken) begin
        wrAddr_q <= haddr[AddrW-1:0];
      end
    end
  end

  // Write strobes in the data phase
  assign wrCtl = wrPend_q && (wrAddr_q == `TCI_OFS_CTL);
  assign wrPeriod = wrPend_q && (wrAddr_q == `TCI_OFS_PERIOD);
  assign wrPrescale = wrPend_q && (wrAddr_q == `TCI_OFS_PRESCALE);

  // ==========================================================
  // Control/status word, reserved bits read zero
  always_comb begin
    ctlWord = '0;
    ctlWord[`TCI_BIT_ZFLAG] = zero_flag_q;
    ctlWord[`TCI_BIT_ZIRQEN] = zero_irq_enable_q;
    ctlWord[`TCI_BIT_FREE] = free_q;
    ctlWord[`TCI_BIT_SOFT] = soft_q;
  end

  // Read data captured in the address phase; unmapped reads give zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= '0;
    end else if (addrTaken && !hwrite) begin
      case (haddr[AddrW-1:0])
        `TCI_OFS_CTL: begin
          hrdata <= {{(32-`TCI_CTL_W){1'b0}}, ctlWord};
        end
        `TCI_OFS_COUNT: begin
          hrdata <= 32'(countdown_value_q);
        end
        `TCI_OFS_PERIOD: begin
          hrdata <= 32'(reload_period_q);
        end
        `TCI_OFS_PRESCALE: begin
          hrdata <= 32'(prescale_divisor_q);
        end
        default: begin
          hrdata <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // Mode and enable bits
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      zero_irq_enable_q <= 1'b0;
      free_q <= 1'b0;
      soft_q <= 1'b0;
    end else if (wrCtl) begin
      zero_irq_enable_q <= hwdata[`TCI_BIT_ZIRQEN];
      free_q <= hwdata[`TCI_BIT_FREE];
      soft_q <= hwdata[`TCI_BIT_SOFT];
    end
  end

  // Period and prescale registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reload_period_q <= CntW'(`TCI_PERIOD_RST);
      prescale_divisor_q <= CntW'(`TCI_PRESCALE_RST);
    end else begin
      if (wrPeriod) begin
        reload_period_q <= CntW'(hwdata);
      end
      if (wrPrescale) begin
        prescale_divisor_q <= CntW'(hwdata);
      end
    end
  end

  // ==========================================================
  // Prescaler and halt gate
  tci_prescaler #(
    .CntW(CntW)
  ) i_tci_prescaler (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .runEn(runEn),
    .divisor(prescale_divisor_q),
    .tick(decTick)
  );

  tci_emu_gate i_tci_emu_gate (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .dbgHalt(dbgHalt),
    .freeRun(free_q),
    .softStop(soft_q),
    .decTick(decTick),
    .zeroEvt(zeroEvt),
    .runEn(runEn)
  );

  // ==========================================================
  // Countdown: a tick at zero reloads, otherwise decrements
  // decrement and reload
  always_comb begin
    if (countdown_value_q == '0) begin
      countdown_value_d = reload_period_q;
    end else begin
      countdown_value_d = countdown_value_q - 1'b1;
    end
  end

  // Zero reached by this tick; a zero period fires on every tick
  assign zeroEvt = decTick && (countdown_value_d == '0);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      countdown_value_q <= CntW'(`TCI_PERIOD_RST);
    end else if (decTick) begin
      countdown_value_q <= countdown_value_d;
    end
  end

  // Timer interrupt pulse, on the same edge that takes the count to zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      zeroPulse <= 1'b0;
    end else begin
      zeroPulse <= zeroEvt;
    end
  end

  // ==========================================================
  // Zero flag, write one to clear; a new event beats the clear
  assign zeroClr = wrCtl && hwdata[`TCI_BIT_ZFLAG];

  // set on zero, clear on one, zero ignored
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      zero_flag_q <= 1'b0;
    end else if (zeroEvt) begin
      zero_flag_q <= 1'b1;
    end else if (zeroClr) begin
      zero_flag_q <= 1'b0;
    end
  end

  // soft stop still flags zero first
  assign irq = zero_flag_q && zero_irq_enable_q;

  // ==========================================================
  // Checks
  property p_flag_set;
    @(posedge core_clk) disable iff (!rst_b)
      zeroEvt |=> zero_flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("zero flag not set");

  property p_flag_clr;
    @(posedge core_clk) disable iff (!rst_b)
      zeroClr && !zeroEvt |=> !zero_flag_q;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("zero flag not cleared");

  property p_flag_keep;
    @(posedge core_clk) disable iff (!rst_b)
      zero_flag_q && !zeroClr |=> zero_flag_q;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("zero flag lost");

  property p_irq_off;
    @(posedge core_clk) disable iff (!rst_b)
      !zero_irq_enable_q |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

  property p_irq_on;
    @(posedge core_clk) disable iff (!rst_b)
      zeroEvt && zero_irq_enable_q && !wrCtl |=> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing on zero");

  property p_free_run;
    @(posedge core_clk) disable iff (!rst_b)
      free_q && $past(free_q) |-> runEn;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run halted");

  property p_soft_irq;
    @(posedge core_clk) disable iff (!rst_b)
      $fell(runEn) && soft_q |-> zeroPulse;
  endproperty
  a_soft_irq: assert property (p_soft_irq) else $error("soft stop without zero");

  property p_dec;
    @(posedge core_clk) disable iff (!rst_b)
      decTick && (countdown_value_q != '0) |=>
        countdown_value_q == $past(countdown_value_q) - 1'b1;
  endproperty
  a_dec: assert property (p_dec) else $error("count did not drop by one");

  property p_reload;
    @(posedge core_clk) disable iff (!rst_b)
      decTick && (countdown_value_q == '0) && !wrPeriod |=>
        countdown_value_q == $past(reload_period_q);
  endproperty
  a_reload: assert property (p_reload) else $error("count not reloaded");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_b)
      !runEn |=> $stable(countdown_value_q);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while halted");

  c_irq: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(irq));
  c_free: cover property (@(posedge core_clk) disable iff (!rst_b)
    dbgHalt && free_q && zeroEvt);
  c_clr: cover property (@(posedge core_clk) disable iff (!rst_b) zeroClr && zeroEvt);

endmodule

/* File: sim/tci_far_end.sv */
/*
  Far-end model: the debug halt controller that drives the timer's halt input.
  Assumes haltReq and slowHalt are driven by the bench right after core_clk edges.
*/
`timescale 1ns/1ps

module tci_far_end (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Bench commands
  input wire logic haltReq,
  input wire logic slowHalt,
  // Timer side
  output logic dbgHalt
);
  logic haltDly_q;

  // ==========================================================
  // Halt level, optionally one cycle late like a slow debugger
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      haltDly_q <= 1'b0;
      dbgHalt <= 1'b0;
    end else begin
      haltDly_q <= haltReq;
      dbgHalt <= slowHalt ? haltDly_q : haltReq;
    end
  end
endmodule

/* File: sim/tci_timer_ctl_tb.sv */
/*
  Self-checking bench for the timer control block: bus reads, zero events,
  interrupt gating and the debug halt modes.
  Assumes the design files and tci_params.svh are on the include path.
*/
`timescale 1ns/1ps
`include "tci_params.svh"

module tci_timer_ctl_tb;
  import tci_pkg::*;
  // Narrow counter keeps the first countdown short
  localparam int CW = 8;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  tci_trans_t htrans = 2'h0;
  tci_size_t hsize = 3'h2;
  logic haltReq = 1'b0;
  logic slowHalt = 1'b0;
  logic rdPh = 1'b0;
  logic hready, hreadyout, hresp, dbgHalt, zeroPulse, irq;
  logic [31:0] hrdata;
  logic [31:0] rng = 32'h00014531;
  logic [31:0] expQ[$];
  int errors = 0;
  int checkCount = 0;
  int cyc = 0;
  int pulseCnt = 0;

  // ==========================================================
  // Clock, single slave ready loop, design and far end
  always #25 core_clk = ~core_clk;
  assign hready = hreadyout;

  tci_timer_ctl #(.CntW(CW)) i_tci_timer_ctl (
    .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .dbgHalt(dbgHalt), .zeroPulse(zeroPulse), .irq(irq)
  );

  tci_far_end i_tci_far_end (
    .core_clk(core_clk), .rst_b(rst_b), .haltReq(haltReq),
    .slowHalt(slowHalt), .dbgHalt(dbgHalt)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("errors=%0d checks=%0d", errors, checkCount);
    if (errors == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One single word transfer; expected read data goes on the queue
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= `TCI_TRANS_NONSEQ;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h00000000;
    if (!wr) expQ.push_back(e);
    do @(posedge core_clk); while (hready !== 1'b1);
  endtask

  // Counts cycles up to the next zero pulse; zero means none came
  task automatic waitZero(input int lim, output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (zeroPulse !== 1'b1 && n < lim);
    if (zeroPulse !== 1'b1) n = 0;
  endtask

  // ==========================================================
  // Watcher: read data at the data-phase edge, zero pulses, hang limit
  always @(posedge core_clk) begin
    cyc++;
    if (rdPh && hready === 1'b1 && expQ.size() > 0) chk(hrdata, expQ.pop_front());
    if (hready === 1'b1) rdPh <= hsel && htrans == `TCI_TRANS_NONSEQ && !hwrite;
    if (zeroPulse === 1'b1) pulseCnt++;
    if (cyc == 30000) begin
      errors++;
      summarize();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    int n, d, p, c0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    // Reset values, then an unmapped place that ignores writes
    bus(1'b0, `TCI_OFS_CTL, 32'h0, 32'h00000000);
    bus(1'b0, `TCI_OFS_PERIOD, 32'h0, 32'h000000FF);
    bus(1'b0, `TCI_OFS_PRESCALE, 32'h0, 32'h00000000);
    bus(1'b1, 8'h10, 32'hFFFFFFFF, 32'h0);
    bus(1'b0, 8'h10, 32'h0, 32'h00000000);
    chk(32'(hresp), 32'h0);
    chk(32'(hreadyout), 32'h1);
    // Random period and divisor: spacing of zero events
    for (int i = 0; i < 2; i++) begin
      d = int'(xs() % 4);
      p = 2 + int'(xs() % 4);
      bus(1'b1, `TCI_OFS_PERIOD, 32'(p), 32'h0);
      bus(1'b1, `TCI_OFS_PRESCALE, 32'(d), 32'h0);
      bus(1'b1, `TCI_OFS_CTL, 32'h00004000, 32'h0);
      waitZero(1100, n);
      waitZero(40, n);
      chk(32'(n), 32'((p + 1) * (d + 1)));
      chk(32'(irq), 32'h1);
    end
    // Enable off, zero written to the flag: flag kept, request quiet
    bus(1'b1, `TCI_OFS_CTL, 32'h00000000, 32'h0);
    waitZero(40, n);
    chk(32'(irq), 32'h0);
    bus(1'b0, `TCI_OFS_CTL, 32'h0, 32'h00008000);
    // Every emulation mode under a debug halt
    bus(1'b1, `TCI_OFS_PRESCALE, 32'h0, 32'h0);
    bus(1'b1, `TCI_OFS_PERIOD, 32'h00000014, 32'h0);
    for (int m = 0; m < 4; m++) begin
      slowHalt <= m[0];
      bus(1'b1, `TCI_OFS_CTL, 32'h00004000 | 32'(m << 10), 32'h0);
      waitZero(40, n);
      @(posedge core_clk) haltReq <= 1'b1;
      @(negedge core_clk);
      c0 = pulseCnt;
      repeat (63) @(negedge core_clk);
      n = pulseCnt - c0;
      if (m >= 2) begin
        chk(32'(n >= 2), 32'h1);
      end else if (m == 1) begin
        chk(32'(n), 32'h1);
        bus(1'b0, `TCI_OFS_COUNT, 32'h0, 32'h00000000);
        bus(1'b0, `TCI_OFS_CTL, 32'h0, 32'h0000C400);
      end else begin
        // Held timer makes the flag writes free of races
        chk(32'(n), 32'h0);
        // Reload to 0x14, two drops before the halt is seen, one drop to stop
        bus(1'b0, `TCI_OFS_COUNT, 32'h0, 32'h00000011);
        bus(1'b1, `TCI_OFS_CTL, 32'h00004000, 32'h0);
        bus(1'b0, `TCI_OFS_CTL, 32'h0, 32'h0000C000);
        bus(1'b1, `TCI_OFS_CTL, 32'h0000C000, 32'h0);
        bus(1'b0, `TCI_OFS_CTL, 32'h0, 32'h00004000);
        @(negedge core_clk);
        chk(32'(irq), 32'h0);
      end
      @(posedge core_clk) haltReq <= 1'b0;
      waitZero(30, n);
      chk(32'(n > 0), 32'h1);
    end
    summarize();
  end
endmodule
